// file: aobs_top.sv
// Analog output buffer sequencer: APB registers, sample FIFO, group drain.
// Assumes APB master in the clk_sys_i domain; ext_clk_i is synchronous.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Simultaneous select bit in board control switches outputs to simultaneous update.
// - Threshold flag goes low whenever buffer count falls below threshold.
// - Rate register write sets the internal generator sample frequency.
// - With external clocking, sample clocks come from the external input.
// - Output clock gate high enables sample clocking at the selected rate.
// - Rate run bit starts the internal generator when internal clocking selected.
// - Flush bit discards all buffered values, leaving the buffer empty.
// - Each sample clock that finds a whole group buffered while idle delivers one value to every active channel.
// - Buffer accepts fast loading without losing data.
// - Writes above one million samples per second accumulate in the buffer.
// - Simultaneous mode holds a group until complete, then updates outputs together.
// - Only the low sixteen bits of each buffer word form the sample.
module aobs_top #(
	parameter int CH = 4,
	parameter int DEPTH = 64,
	parameter int DW = 16,
	parameter int RW = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// External sample clock
	input wire logic ext_clk_i,
	// Converter side
	output logic [CH*DW-1:0] dac_data_o,
	output logic [CH-1:0] dac_load_o,
	// Status
	output logic thr_flag_o,
	output logic irq_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = (CH > 1) ? $clog2(CH) : 1;

	// Refuse shapes the pointer logic cannot serve
	generate
		if (DEPTH < CH || (1 << AW) != DEPTH || DW > 16 || AW > 15 || RW > 32) begin : g_chk
			$error("aobs_top: unsupported parameters");
		end
	endgenerate

	// Registers
	logic [1:0] bcr_reg;
	logic [1:0] bop_reg;
	logic flush_reg;
	logic [RW-1:0] rate_reg;
	logic [AW:0] thr_reg;
	logic [CH-1:0] chan_en_reg;
	localparam int IRQ_W_L = aobs_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irq_stat_reg;
	logic [IRQ_W_L-1:0] irq_en_reg;

	// FIFO storage
	logic [DW-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic full;
	logic empty;

	// Sequencer
	aobs_pkg::aobs_state_e state_reg;
	logic [CW-1:0] ch_reg;
	logic [DW-1:0] hold_reg [CH];
	logic ext_prev_reg;
	logic rate_tick;
	logic sample_tick;
	logic [AW:0] active_n;
	logic pop;
	logic last_ch;
	logic simul;
	logic thr_prev_reg;

	// APB decode
	logic acc;
	logic wr_en;
	logic rd_ok;
	logic push;
	logic [31:0] rd_data;

	assign simul = bcr_reg[aobs_pkg::BCR_SIMUL_BIT];
	assign full = count_reg == (AW+1)'(DEPTH);
	assign empty = count_reg == '0;
	assign acc = psel_i && penable_i;
	assign wr_en = acc && pwrite_i && pready_o;
	assign push = wr_en && paddr_i == aobs_pkg::OFF_DATA && !flush_reg;

	// Number of active channels in a group
	always_comb begin
		active_n = '0;
		for (int i = 0; i < CH; i++) begin
			active_n = active_n + (AW+1)'(chan_en_reg[i]);
		end
	end

	// Read mux; unmapped offsets raise pslverr
	always_comb begin
		rd_data = '0;
		rd_ok = 1'b1;
		case (paddr_i)
			aobs_pkg::OFF_BOARD_CTRL: rd_data[1:0] = bcr_reg;
			aobs_pkg::OFF_BUF_OPS: rd_data[1:0] = bop_reg;
			aobs_pkg::OFF_OUT_OPS: rd_data[aobs_pkg::OOP_FLUSH_BIT] = flush_reg;
			aobs_pkg::OFF_RATE: rd_data[RW-1:0] = rate_reg;
			aobs_pkg::OFF_THRESH: rd_data[AW:0] = thr_reg;
			aobs_pkg::OFF_CHAN_EN: rd_data[CH-1:0] = chan_en_reg;
			aobs_pkg::OFF_DATA: rd_data = '0;
			aobs_pkg::OFF_STATUS: begin
				rd_data[aobs_pkg::ST_COUNT_LSB +: AW+1] = count_reg;
				rd_data[aobs_pkg::ST_FLAG_BIT] = thr_flag_o;
				rd_data[aobs_pkg::ST_EMPTY_BIT] = empty;
				rd_data[aobs_pkg::ST_FULL_BIT] = full;
			end
			aobs_pkg::OFF_IRQ_STAT: rd_data[IRQ_W_L-1:0] = irq_stat_reg;
			aobs_pkg::OFF_IRQ_EN: rd_data[IRQ_W_L-1:0] = irq_en_reg;
			aobs_pkg::OFF_IRQ_CLR: rd_data = '0;
			default: rd_ok = 1'b0;
		endcase
	end

	// Bus answer: one wait state; a data write stalls while the buffer is full
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= '0;
		end else if (acc && !pready_o) begin
			if (!(pwrite_i && paddr_i == aobs_pkg::OFF_DATA && full)) begin
				pready_o <= 1'b1;
				pslverr_o <= !rd_ok;
				prdata_o <= pwrite_i ? 32'h0000_0000 : rd_data;
			end
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	// Control registers
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			bcr_reg <= aobs_pkg::BCR_RST;
			bop_reg <= aobs_pkg::BOP_RST;
			rate_reg <= RW'(aobs_pkg::RATE_DIV_RST);
			thr_reg <= (AW+1)'(aobs_pkg::THRESH_RST);
			chan_en_reg <= {CH{aobs_pkg::CHAN_EN_RST_BIT}};
			irq_en_reg <= aobs_pkg::IRQ_EN_RST;
		end else if (wr_en) begin
			case (paddr_i)
				aobs_pkg::OFF_BOARD_CTRL: bcr_reg <= pwdata_i[1:0];
				aobs_pkg::OFF_BUF_OPS: bop_reg <= pwdata_i[1:0];
				aobs_pkg::OFF_RATE: rate_reg <= pwdata_i[RW-1:0];
				aobs_pkg::OFF_THRESH: thr_reg <= pwdata_i[AW:0];
				aobs_pkg::OFF_CHAN_EN: chan_en_reg <= pwdata_i[CH-1:0];
				aobs_pkg::OFF_IRQ_EN: irq_en_reg <= pwdata_i[IRQ_W_L-1:0];
				default: ;
			endcase
		end
	end

	// Flush request: acts the cycle after the write, then clears itself
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			flush_reg <= 1'b0;
		end else begin
			flush_reg <= wr_en && paddr_i == aobs_pkg::OFF_OUT_OPS
				&& pwdata_i[aobs_pkg::OOP_FLUSH_BIT];
		end
	end

	// Internal generator runs only when selected and started
	aobs_rate_gen #(
		.RW(RW)
	) u_rate (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.run_i(bcr_reg[aobs_pkg::BCR_RATE_RUN_BIT] && bop_reg[aobs_pkg::BOP_INT_CLK_BIT]),
		.div_i(rate_reg),
		.tick_o(rate_tick)
	);

	// External clock edge; the input is already synchronous
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_clk_i;
		end
	end

	// Source select and gate
	assign sample_tick = bop_reg[aobs_pkg::BOP_CLK_GATE_BIT]
		&& (bop_reg[aobs_pkg::BOP_INT_CLK_BIT] ? rate_tick
		: (ext_clk_i && !ext_prev_reg));

	assign last_ch = ch_reg == CW'(CH - 1);
	assign pop = state_reg == aobs_pkg::ST_DRAIN && chan_en_reg[ch_reg] && !empty && !flush_reg;

	// FIFO pointers and count; flush wins over all traffic
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || flush_reg) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Sample storage; upper bits of the bus word are dropped
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= pwdata_i[DW-1:0];
		end
	end

	// Group drain: start on a tick only when a whole group is buffered
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || flush_reg) begin
			state_reg <= aobs_pkg::ST_IDLE;
			ch_reg <= '0;
		end else begin
			case (state_reg)
				aobs_pkg::ST_IDLE: begin
					ch_reg <= '0;
					if (sample_tick && active_n != '0 && count_reg >= active_n) begin
						state_reg <= aobs_pkg::ST_DRAIN;
					end
				end
				aobs_pkg::ST_DRAIN: begin
					ch_reg <= ch_reg + CW'(1);
					if (last_ch) begin
						state_reg <= simul ? aobs_pkg::ST_COMMIT : aobs_pkg::ST_IDLE;
					end
				end
				aobs_pkg::ST_COMMIT: state_reg <= aobs_pkg::ST_IDLE;
				default: state_reg <= aobs_pkg::ST_IDLE;
			endcase
		end
	end

	// Converter outputs: sequential loads per value, simultaneous loads at commit
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			dac_data_o <= '0;
			dac_load_o <= '0;
			for (int i = 0; i < CH; i++) begin
				hold_reg[i] <= '0;
			end
		end else begin
			dac_load_o <= '0;
			if (pop) begin
				hold_reg[ch_reg] <= mem_reg[rd_ptr_reg];
				if (!simul) begin
					dac_data_o[ch_reg*DW +: DW] <= mem_reg[rd_ptr_reg];
					dac_load_o[ch_reg] <= 1'b1;
				end
			end
			if (state_reg == aobs_pkg::ST_COMMIT && !flush_reg) begin
				for (int i = 0; i < CH; i++) begin
					if (chan_en_reg[i]) begin
						dac_data_o[i*DW +: DW] <= hold_reg[i];
					end
				end
				dac_load_o <= chan_en_reg;
			end
		end
	end

	// Threshold flag: high while the count reaches the threshold
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			thr_flag_o <= 1'b0;
			thr_prev_reg <= 1'b0;
		end else begin
			thr_flag_o <= count_reg >= thr_reg;
			thr_prev_reg <= thr_flag_o;
		end
	end

	// Sticky events; a set in the clear cycle wins
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_stat_reg <= '0;
			irq_o <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg
				& ~((wr_en && paddr_i == aobs_pkg::OFF_IRQ_CLR) ? pwdata_i[IRQ_W_L-1:0] : '0))
				| {state_reg == aobs_pkg::ST_COMMIT || (state_reg == aobs_pkg::ST_DRAIN
					&& last_ch && !simul),
				sample_tick && state_reg == aobs_pkg::ST_IDLE
					&& (active_n == '0 || count_reg < active_n),
				thr_prev_reg && !thr_flag_o};
			irq_o <= |(irq_stat_reg & irq_en_reg);
		end
	end

	a_thr_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(count_reg < thr_reg) |=> !thr_flag_o)
		else $error("threshold flag high below threshold");
	a_flush_empty: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		flush_reg |=> (count_reg == '0 && !flush_reg && state_reg == aobs_pkg::ST_IDLE))
		else $error("flush did not empty buffer");
	a_flush_selfclr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(flush_reg && !(wr_en && paddr_i == aobs_pkg::OFF_OUT_OPS)) |=> !flush_reg)
		else $error("flush bit stuck");
	a_simul_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(simul && state_reg == aobs_pkg::ST_DRAIN && $past(simul)) |=> dac_load_o == '0)
		else $error("simultaneous output updated early");
	a_gate_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!bop_reg[aobs_pkg::BOP_CLK_GATE_BIT] && state_reg == aobs_pkg::ST_IDLE)
		|=> state_reg == aobs_pkg::ST_IDLE)
		else $error("drain started with clock gated");
	a_ext_source: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!bop_reg[aobs_pkg::BOP_INT_CLK_BIT] && state_reg == aobs_pkg::ST_IDLE
		&& !(ext_clk_i && !ext_prev_reg)) |=> state_reg == aobs_pkg::ST_IDLE)
		else $error("drain started without external edge");
	a_int_run: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!(bcr_reg[aobs_pkg::BCR_RATE_RUN_BIT] && bop_reg[aobs_pkg::BOP_INT_CLK_BIT])
		|=> !rate_tick)
		else $error("rate generator ticks while stopped");
	a_group_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i || flush_reg)
		(state_reg == aobs_pkg::ST_IDLE && sample_tick && active_n != '0 && count_reg >= active_n)
		|=> state_reg == aobs_pkg::ST_DRAIN)
		else $error("group drain did not start");
	a_full_stall: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(acc && pwrite_i && paddr_i == aobs_pkg::OFF_DATA && full && !pready_o) |=> !pready_o)
		else $error("write accepted into full buffer");
	a_low_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		push |=> mem_reg[$past(wr_ptr_reg)] == $past(pwdata_i[DW-1:0]))
		else $error("stored sample differs from low bits");
endmodule : aobs_top
`default_nettype wire

// file: aobs_pkg.sv
// Constants shared by the analog output buffer sequencer and its rate generator.
// Assumes a 50 MHz system clock and 32-bit APB access with byte offsets.
package aobs_pkg;
	// Clock and sample timing
	localparam int CLK_HZ = 50_000_000;
	localparam int DEFAULT_SPS = 320_000;
	localparam int MAX_SPS = 1_000_000;
	localparam int MIN_DIV = CLK_HZ / MAX_SPS;
	localparam int RATE_DIV_RST = CLK_HZ / DEFAULT_SPS;
	// Register byte offsets
	localparam logic [7:0] OFF_BOARD_CTRL = 8'h00;
	localparam logic [7:0] OFF_BUF_OPS = 8'h04;
	localparam logic [7:0] OFF_OUT_OPS = 8'h08;
	localparam logic [7:0] OFF_RATE = 8'h0C;
	localparam logic [7:0] OFF_THRESH = 8'h10;
	localparam logic [7:0] OFF_CHAN_EN = 8'h14;
	localparam logic [7:0] OFF_DATA = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFF_IRQ_EN = 8'h24;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
	// Field positions
	localparam int BCR_SIMUL_BIT = 0;
	localparam int BCR_RATE_RUN_BIT = 1;
	localparam int BOP_INT_CLK_BIT = 0;
	localparam int BOP_CLK_GATE_BIT = 1;
	localparam int OOP_FLUSH_BIT = 0;
	localparam int ST_COUNT_LSB = 0;
	localparam int ST_FLAG_BIT = 16;
	localparam int ST_EMPTY_BIT = 17;
	localparam int ST_FULL_BIT = 18;
	localparam int IRQ_THR_LOW = 0;
	localparam int IRQ_UNDERRUN = 1;
	localparam int IRQ_GROUP = 2;
	localparam int IRQ_W = 3;
	// Values after reset
	localparam logic [1:0] BCR_RST = 2'h0;
	localparam logic [1:0] BOP_RST = 2'h0;
	localparam logic [31:0] THRESH_RST = 32'h0000_0000;
	localparam logic CHAN_EN_RST_BIT = 1'b1;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
	// Drain sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_DRAIN, ST_COMMIT} aobs_state_e;
endpackage : aobs_pkg

// file: aobs_rate_gen.sv
// Internal output rate generator: one-cycle tick every divisor clocks.
// Assumes divisor comes from a register in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module aobs_rate_gen #(
	parameter int RW = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Control
	input wire logic run_i,
	input wire logic [RW-1:0] div_i,
	// Sample enable
	output logic tick_o
);
	logic [RW-1:0] eff_div;
	logic [RW-1:0] cnt_reg;
	logic [RW-1:0] gap_reg;
	logic seen_reg;
	logic same_reg;

	// Clamp keeps the tick rate at or below the converter limit
	assign eff_div = (div_i < RW'(aobs_pkg::MIN_DIV)) ? RW'(aobs_pkg::MIN_DIV) : div_i;

	// Divider counter
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || !run_i) begin
			cnt_reg <= '0;
			tick_o <= 1'b0;
		end else if (cnt_reg >= eff_div - RW'(1)) begin
			cnt_reg <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + RW'(1);
			tick_o <= 1'b0;
		end
	end

	// Helper: spacing between ticks, for the checks below
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || !run_i) begin
			gap_reg <= '0;
			seen_reg <= 1'b0;
			same_reg <= 1'b0;
		end else begin
			gap_reg <= tick_o ? '0 : gap_reg + RW'(1);
			if (tick_o) begin
				seen_reg <= 1'b1;
			end
			if (tick_o) begin
				same_reg <= 1'b1;
			end else if ($changed(div_i)) begin
				same_reg <= 1'b0;
			end
		end
	end

	a_period_div: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(tick_o && seen_reg && same_reg && run_i && !$changed(div_i)) |-> gap_reg == eff_div - RW'(1))
		else $error("rate tick spacing differs from divisor");
	a_min_period: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(tick_o && seen_reg) |-> gap_reg >= RW'(aobs_pkg::MIN_DIV - 1))
		else $error("rate tick faster than converter limit");
endmodule : aobs_rate_gen
`default_nettype wire

// file: aobs_far_model.sv
// Converter-side model: makes the external sample clock and records loads.
// Assumes loads and data are registered in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module aobs_far_model #(
	parameter int CH = 4
) (
	// Clock
	input wire logic clk_sys_i,
	// Converter side
	input wire logic [CH*16-1:0] dac_data_i,
	input wire logic [CH-1:0] dac_load_i,
	// External sample clock
	output logic ext_clk_o
);
	logic [15:0] val [CH];
	logic [CH-1:0] last_mask;
	int cyc;
	int n_events;
	int t_prev;
	int t_last;
	// Clock stands still low between requested pulses
	initial begin
		ext_clk_o = 1'b0;
		cyc = 0;
		n_events = 0;
		t_prev = 0;
		t_last = 0;
		last_mask = '0;
	end
	// Stamp each load event so the bench can time sample ticks
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (|dac_load_i) begin
			n_events <= n_events + 1;
			last_mask <= dac_load_i;
			t_prev <= t_last;
			t_last <= cyc;
			for (int i = 0; i < CH; i++) begin
				if (dac_load_i[i]) begin
					val[i] <= dac_data_i[i*16+:16];
				end
			end
		end
	end
	// One external clock: two system clocks high, then low
	task automatic ext_tick();
		@(posedge clk_sys_i);
		ext_clk_o <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		ext_clk_o <= 1'b0;
	endtask : ext_tick
endmodule : aobs_far_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the output buffer sequencer over APB.
// Assumes default parameters: four channels, 64-deep buffer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd_val;
	logic pready_o, pslverr_o, ext_clk, thr_flag_o, irq_o, rd_err;
	logic [63:0] dac_data;
	logic [3:0] dac_load;
	int err_count, tests_run;
	aobs_top #(.CH(4), .DEPTH(64), .DW(16), .RW(16)) DUT (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .ext_clk_i(ext_clk), .dac_data_o(dac_data),
		.dac_load_o(dac_load), .thr_flag_o(thr_flag_o), .irq_o(irq_o));
	aobs_far_model #(.CH(4)) FAR (.clk_sys_i(clk_sys_i), .dac_data_i(dac_data),
		.dac_load_i(dac_load), .ext_clk_o(ext_clk));
	// 50 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask : check
	// One APB transfer; two extra edges let registered flags settle
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		paddr_i <= a;
		pwrite_i <= w;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready_o !== 1'b1 && n < 200);
		if (pready_o !== 1'b1) check(32'h0, 32'h1, "no pready");
		rd_val = prdata_o;
		rd_err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
		apb(a, 1'b0, 32'h0);
		check(rd_val, exp, msg);
	endtask : rd
	// Bounded wait for a given number of load events
	task automatic wait_ev(input int e);
		int n;
		n = 0;
		while (FAR.n_events < e && n < 2000) begin
			@(posedge clk_sys_i);
			n++;
		end
		check(32'(FAR.n_events), 32'(e), "load events");
	endtask : wait_ev
	// Status word: count, flag, empty
	function automatic logic [31:0] st(input int c, input logic f);
		return 32'(c) | (32'(f) << aobs_pkg::ST_FLAG_BIT) | (32'(c == 0) << aobs_pkg::ST_EMPTY_BIT);
	endfunction : st
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		err_count++;
		end_of_test();
	end
	// Main sequence
	initial begin
		{rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		err_count = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(aobs_pkg::OFF_BOARD_CTRL, 32'h0000_0000, "bcr reset");
		rd(aobs_pkg::OFF_BUF_OPS, 32'h0000_0000, "buf ops reset");
		rd(aobs_pkg::OFF_RATE, 32'(aobs_pkg::RATE_DIV_RST), "rate reset");
		rd(aobs_pkg::OFF_CHAN_EN, 32'h0000_000F, "chan en reset");
		rd(aobs_pkg::OFF_IRQ_EN, 32'h0000_0000, "irq en reset");
		apb(8'h30, 1'b0, 32'h0000_0000);
		check(rd_err, 1'b1, "unmapped error");
		// External clocking: rate left unprogrammed, gate on
		wr(aobs_pkg::OFF_BUF_OPS, 32'h0000_0002);
		wr(aobs_pkg::OFF_THRESH, 32'h0000_0003);
		wr(aobs_pkg::OFF_OUT_OPS, 32'h0000_0001);
		rd(aobs_pkg::OFF_OUT_OPS, 32'h0000_0000, "flush clear");
		for (int k = 0; k < 4; k++) begin
			wr(aobs_pkg::OFF_DATA, {16'hDEAD, 16'h1230 + 16'(k)});
			check(thr_flag_o, k >= 2, "flag vs count");
		end
		rd(aobs_pkg::OFF_STATUS, st(4, 1'b1), "held values");
		FAR.ext_tick();
		repeat (12) @(posedge clk_sys_i);
		check(32'(FAR.n_events), 32'h4, "sequential loads");
		for (int k = 0; k < 4; k++) begin
			check(FAR.val[k], 16'h1230 + 16'(k), "channel value");
		end
		check(thr_flag_o, 1'b0, "flag low");
		// Interrupt: latched, masked, enabled, cleared
		rd(aobs_pkg::OFF_IRQ_STAT, 32'h0000_0005, "irq status");
		check(irq_o, 1'b0, "irq masked");
		wr(aobs_pkg::OFF_IRQ_EN, 32'h0000_0005);
		check(irq_o, 1'b1, "irq raised");
		wr(aobs_pkg::OFF_IRQ_CLR, 32'h0000_0005);
		check(irq_o, 1'b0, "irq cleared");
		rd(aobs_pkg::OFF_IRQ_STAT, 32'h0000_0000, "irq status clear");
		// Gate off: ticks must not drain
		wr(aobs_pkg::OFF_BUF_OPS, 32'h0000_0000);
		for (int k = 0; k < 4; k++) wr(aobs_pkg::OFF_DATA, 32'(k));
		FAR.ext_tick();
		repeat (12) @(posedge clk_sys_i);
		check(32'(FAR.n_events), 32'h4, "gated off");
		rd(aobs_pkg::OFF_STATUS, st(4, 1'b1), "still held");
		// Fill to the brim; the next data write must wait for a drain
		for (int k = 4; k < 64; k++) wr(aobs_pkg::OFF_DATA, 32'(k));
		rd(aobs_pkg::OFF_STATUS, st(64, 1'b1) | (32'h0000_0001 << aobs_pkg::ST_FULL_BIT), "full");
		wr(aobs_pkg::OFF_BUF_OPS, 32'h0000_0002);
		fork
			wr(aobs_pkg::OFF_DATA, 32'h0000_6000);
			begin
				repeat (10) @(posedge clk_sys_i);
				FAR.ext_tick();
			end
		join
		rd(aobs_pkg::OFF_STATUS, st(61, 1'b1), "no word lost");
		check(32'(FAR.n_events), 32'h0000_0008, "drain frees slot");
		check(FAR.val[3], 16'h0003, "full drain order");
		wr(aobs_pkg::OFF_OUT_OPS, 32'h0000_0001);
		rd(aobs_pkg::OFF_STATUS, st(0, 1'b0), "flushed");
		// Simultaneous update from the internal generator
		wr(aobs_pkg::OFF_BOARD_CTRL, 32'h0000_0003);
		wr(aobs_pkg::OFF_RATE, 32'h0000_003C);
		wr(aobs_pkg::OFF_BUF_OPS, 32'h0000_0003);
		for (int k = 0; k < 3; k++) wr(aobs_pkg::OFF_DATA, 32'h4000 + 32'(k));
		repeat (150) @(posedge clk_sys_i);
		check(32'(FAR.n_events), 32'h0000_0008, "partial group held");
		wr(aobs_pkg::OFF_DATA, 32'h0000_4003);
		wait_ev(9);
		check(FAR.last_mask, 4'hF, "loads together");
		check(FAR.val[3], 16'h4003, "last of group");
		// Two groups loaded faster than the ticks drain them
		for (int k = 0; k < 8; k++) wr(aobs_pkg::OFF_DATA, 32'h5000 + 32'(k));
		wait_ev(11);
		check(32'(FAR.t_last - FAR.t_prev), 32'h0000_003C, "tick spacing");
		check(FAR.val[0], 16'h5004, "second group");
		rd(aobs_pkg::OFF_STATUS, st(0, 1'b0), "drained below threshold");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
